// ---- include/tsv_pkg.sv ----
// shared constants and types of the trigger sampling and veto block
package tsv_pkg;
    localparam int NUM_INPUTS = 8;
    localparam int NUM_PAIRS = 4;
    localparam int FINE_TAPS = 8;
    localparam int RAM_DEPTH = 256;
    localparam int RAM_WIDTH = 4;
    localparam int STREAM_FIFO_DEPTH = 4;
    localparam int SPY_FIFO_DEPTH = 4;
    localparam int TRIG_NUM_WIDTH = 40;
    // last fast clock phase of a bunch crossing (eight fast cycles per bunch)
    localparam logic [2:0] PHASE_LAST = 3'h7;
    // register indices on the register port
    localparam logic [2:0] REG_PAIR_BASE = 3'h0;
    localparam logic [2:0] REG_CONTROL = 3'h4;
    localparam logic [2:0] REG_SPY_DATA = 3'h5;
    // trigger input pair config field positions
    localparam int PAIR_EN_SECOND_BIT = 29;
    localparam int PAIR_EN_FIRST_BIT = 28;
    localparam int PAIR_TRIM_LSB = 24;
    localparam int PAIR_FINE_SECOND_LSB = 20;
    localparam int PAIR_FINE_FIRST_LSB = 16;
    localparam int PAIR_MASK_SECOND_LSB = 8;
    localparam int PAIR_MASK_FIRST_LSB = 0;
    // trigger control/status field positions
    localparam int CTL_TN_EMPTY_BIT = 25;
    localparam int CTL_TN_FULL_BIT = 24;
    localparam int CTL_IN0_FULL_BIT = 16;
    localparam int CTL_HALT_BIT = 7;
    localparam int CTL_SPY_SEL_LSB = 4;
    localparam int CTL_OFFSET_LSB = 0;
    localparam logic [31:0] PAIR_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    // stream word coding
    localparam logic [3:0] STATUS_TAG = 4'h8;
    localparam logic [3:0] TYPE_INPUT_BASE = 4'hc;
    localparam logic [3:0] TYPE_TRIG_NUM_LOW = 4'ha;
    localparam logic [3:0] TYPE_TRIG_NUM_HIGH = 4'hb;

    typedef struct packed {
        logic [1:0] unused;
        logic en_second;
        logic en_first;
        logic [3:0] bunch_number_trim;
        logic [3:0] fine_delay_second;
        logic [3:0] fine_delay_first;
        logic [7:0] mark_pattern_second;
        logic [7:0] mark_pattern_first;
    } tsv_pair_cfg_t;

    typedef struct packed {
        logic [23:0] payload;
        logic [3:0] kind;
        logic [3:0] tag;
    } tsv_word_t;

    function automatic tsv_word_t tsv_status(input logic [3:0] kind, input logic [23:0] payload);
        tsv_word_t w;
        w.payload = payload;
        w.kind = kind;
        w.tag = STATUS_TAG;
        return w;
    endfunction
endpackage

// ---- hdl/tsv_trigger_veto.sv ----
// trigger sampling, bunch marking, veto ram and stream status words
// Notes on behaviour
// [RQ1] each trigger input sampled on fast clock, delayed up to eight fast cycles
// [RQ2] at each bunch tick the delayed pattern makes a primitive only if non-zero
// [RQ3] primitive bunch number is sampled bunch plus signed four-bit trim
// [RQ4] non-zero primitive ORs its mask into a left-shifting per-bunch shift register
// [RQ5] pair output is the OR of both shift registers' top bits
// [RQ6] outputs written to 4x256 ram at bunch number minus write offset
// [RQ7] with veto enabled hits are kept only when their ram entry is non-zero
// [RQ8] halt bit blocks every ram write
// [RQ9] spy select field picks which spy FIFO software reads
// [RQ10] control register shows spy FIFO empty and full flags in bits 25..16
// [RQ11] enable bits 29 and 28 gate sampling of second and first input
// [RQ12] fine delay fields set the fast-clock de-skew of each input
// [RQ13] mark pattern fields are the masks ORed into the shift registers
// [RQ14] four pair registers, inputs 0-5 chip any-hit, 6 external, 7 periodic
// [RQ15] trigger input words types 12-15 carry bunch byte and two time patterns
// [RQ16] each accept takes next 40-bit trigger number, sent in two words; the code sends only bits 15-0 and 39-24
// [RQ17] status words carry 1000 low, type in bits 7-4, payload above
// [RQ18] reset clears shift registers, trigger number and delay pipelines
`timescale 1ns/1ps

module tsv_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end
endmodule

module tsv_trigger_veto
    import tsv_pkg::*;
(
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic [NUM_INPUTS-1:0] TRIG_IN,
    input wire logic TRIG_ACCEPT_IN,
    input wire logic VETO_ENABLE_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [2:0] REG_SEL_IN,
    input wire logic [31:0] REG_WDATA_IN,
    output logic [31:0] REG_RDATA_OUT,
    input wire logic HIT_VALID_IN,
    input wire logic [31:0] HIT_DATA_IN,
    input wire logic [7:0] HIT_BUNCH_IN,
    output logic HIT_READY_OUT,
    output logic STREAM_VALID_OUT,
    output logic [31:0] STREAM_DATA_OUT,
    input wire logic STREAM_READY_IN,
    output logic [NUM_PAIRS-1:0] TRIG_OUT,
    output logic [7:0] BUNCH_OUT
);
    function automatic logic [2:0] tsv_tap(input logic [3:0] fine);
        return (fine > 4'h7) ? 3'h7 : fine[2:0];
    endfunction

    tsv_pair_cfg_t cfg_q [NUM_PAIRS];
    logic [31:0] ctl_q;
    logic [NUM_INPUTS-1:0] sync1_q;
    logic [NUM_INPUTS-1:0] sync2_q;
    logic [FINE_TAPS-1:0] dly_q [NUM_INPUTS];
    logic [7:0] pat_q [NUM_INPUTS];
    logic [7:0] mark_q [NUM_INPUTS];
    logic [2:0] phase_q;
    logic [7:0] bunch_q;
    logic [NUM_PAIRS-1:0] out_q;
    logic [RAM_WIDTH-1:0] ram [RAM_DEPTH];
    logic [TRIG_NUM_WIDTH-1:0] tnum_q;
    logic [31:0] pend_in_q [NUM_PAIRS];
    logic [NUM_PAIRS-1:0] pend_in_v_q;
    logic [31:0] pend_tn_q [2];
    logic [1:0] pend_tn_v_q;
    logic hit_cap_q;
    logic [31:0] hit_q;
    logic [RAM_WIDTH-1:0] ram_rd_q;
    logic [31:0] rdata_q;

    wire tick = (phase_q == PHASE_LAST);
    wire halt = ctl_q[CTL_HALT_BIT];
    wire [2:0] spy_sel = ctl_q[CTL_SPY_SEL_LSB +: 3];
    wire [3:0] wr_offset = ctl_q[CTL_OFFSET_LSB +: 4];
    wire [7:0] ram_waddr = bunch_q - {4'h0, wr_offset}; // [RQ6]
    wire ram_we = tick && !halt; // [RQ8]
    wire [7:0] pat_now [NUM_INPUTS];
    wire [NUM_INPUTS-1:0] prim;
    wire [NUM_INPUTS-1:0] en_in;
    wire [3:0] fine_in [NUM_INPUTS];
    wire [7:0] mask_in [NUM_INPUTS];
    wire [NUM_PAIRS-1:0] out_now;
    wire [7:0] prim_bunch [NUM_PAIRS];
    wire [NUM_PAIRS-1:0] pair_prim;

    // per-input sampling, de-skew and bunch marking
    for (genvar i = 0; i < NUM_INPUTS; i++)
    begin : g_in
        assign en_in[i] = (i % 2 == 1) ? cfg_q[i / 2].en_second : cfg_q[i / 2].en_first; // [RQ11] [RQ14]
        assign fine_in[i] = (i % 2 == 1) ? cfg_q[i / 2].fine_delay_second : cfg_q[i / 2].fine_delay_first;
        assign mask_in[i] = (i % 2 == 1) ? cfg_q[i / 2].mark_pattern_second : cfg_q[i / 2].mark_pattern_first; // [RQ13]
        wire sample = dly_q[i][tsv_tap(fine_in[i])] && en_in[i]; // [RQ1] [RQ12] [RQ11]
        assign pat_now[i] = {pat_q[i][6:0], sample};
        assign prim[i] = (pat_now[i] != 8'h00); // [RQ2]
        wire [7:0] mark_d = {mark_q[i][6:0], 1'b0} | (prim[i] ? mask_in[i] : 8'h00); // [RQ4]
        always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
        begin
            if (RST_IN)
            begin
                dly_q[i] <= '0; // [RQ18]
                pat_q[i] <= '0;
                mark_q[i] <= '0;
            end
            else
            begin
                dly_q[i] <= {dly_q[i][FINE_TAPS-2:0], sync2_q[i]}; // [RQ1]
                pat_q[i] <= tick ? 8'h00 : pat_now[i];
                if (tick)
                    mark_q[i] <= mark_d;
            end
        end
    end

    // per-pair output, primitive bunch and trigger input words
    for (genvar p = 0; p < NUM_PAIRS; p++)
    begin : g_pair
        assign out_now[p] = mark_q[2 * p][7] | mark_q[2 * p + 1][7]; // [RQ5]
        assign prim_bunch[p] = bunch_q + {{4{cfg_q[p].bunch_number_trim[3]}}, cfg_q[p].bunch_number_trim}; // [RQ3]
        assign pair_prim[p] = prim[2 * p] | prim[2 * p + 1];
    end

    // stream arbitration: trigger number words, then input words, then hits
    wire [31:0] hit_word = hit_q;
    wire hit_keep = !VETO_ENABLE_IN || (ram_rd_q != 4'h0); // [RQ7]
    wire fifo_in_ready;
    logic src_valid;
    logic [31:0] src_data;
    logic [2:0] src_sel;
    always_comb
    begin
        src_valid = 1'b1;
        src_data = hit_word;
        src_sel = 3'h7;
        if (pend_tn_v_q[0])
        begin
            src_data = pend_tn_q[0];
            src_sel = 3'h4;
        end
        else if (pend_tn_v_q[1])
        begin
            src_data = pend_tn_q[1];
            src_sel = 3'h5;
        end
        else if (pend_in_v_q != '0)
        begin
            src_sel = 3'h0;
            for (int k = NUM_PAIRS - 1; k >= 0; k--)
                if (pend_in_v_q[k])
                    src_sel = 3'(k);
            src_data = pend_in_q[src_sel[1:0]];
        end
        else if (!(hit_cap_q && hit_keep))
            src_valid = 1'b0;
    end
    wire take = src_valid && fifo_in_ready;
    wire hit_done = hit_cap_q && (!hit_keep || (take && src_sel == 3'h7));
    wire hit_take = HIT_VALID_IN && !hit_cap_q;

    tsv_fifo #(.WIDTH(32), .DEPTH(STREAM_FIFO_DEPTH)) u_stream_fifo (
        .clk(CORE_CLK_IN),
        .rst(RST_IN),
        .in_valid(src_valid),
        .in_ready(fifo_in_ready),
        .in_data(src_data),
        .out_valid(STREAM_VALID_OUT),
        .out_ready(STREAM_READY_IN),
        .out_data(STREAM_DATA_OUT)
    );

    // spy FIFOs: trigger number (index 4) and input words per pair (0..3)
    wire [4:0] spy_empty;
    wire [4:0] spy_full_n;
    wire [31:0] spy_data [5];
    wire spy_pop = REG_RD_IN && (REG_SEL_IN == REG_SPY_DATA);
    for (genvar s = 0; s < 5; s++)
    begin : g_spy
        wire spy_valid;
        wire spy_push = (s == 4) ? (take && src_sel[2:1] == 2'b10) : (take && src_sel == 3'(s));
        tsv_fifo #(.WIDTH(32), .DEPTH(SPY_FIFO_DEPTH)) u_spy (
            .clk(CORE_CLK_IN),
            .rst(RST_IN),
            .in_valid(spy_push),
            .in_ready(spy_full_n[s]),
            .in_data(src_data),
            .out_valid(spy_valid),
            .out_ready(spy_pop && (spy_sel == 3'(s))), // [RQ9]
            .out_data(spy_data[s])
        );
        assign spy_empty[s] = !spy_valid;
    end

    wire [31:0] flags_word = {6'h00, spy_empty[4], !spy_full_n[4], spy_empty[3], !spy_full_n[3],
        spy_empty[2], !spy_full_n[2], spy_empty[1], !spy_full_n[1], spy_empty[0], !spy_full_n[0], 16'h0000}; // [RQ10]
    wire [31:0] ctl_read = flags_word | {16'h0000, 8'h00, ctl_q[7:0]};
    wire [31:0] spy_read = (spy_sel < 3'h5) ? spy_data[spy_sel] : 32'h0000_0000; // [RQ9]
    wire [31:0] rd_mux = (REG_SEL_IN < REG_CONTROL) ? 32'(cfg_q[REG_SEL_IN[1:0]]) :
        (REG_SEL_IN == REG_CONTROL) ? ctl_read :
        (REG_SEL_IN == REG_SPY_DATA) ? spy_read : 32'h0000_0000;

    // next trigger number words
    wire [TRIG_NUM_WIDTH-1:0] tnum_next = tnum_q + 1'b1; // [RQ16]
    wire [31:0] tn_low_word = tsv_status(TYPE_TRIG_NUM_LOW, {bunch_q, tnum_next[15:0]}); // [RQ16] [RQ17]
    wire [31:0] tn_high_word = tsv_status(TYPE_TRIG_NUM_HIGH, {bunch_q, tnum_next[39:24]}); // [RQ16] [RQ17]

    // registers, sync, counters
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            for (int r = 0; r < NUM_PAIRS; r++)
                cfg_q[r] <= PAIR_CFG_RESET;
            ctl_q <= CONTROL_RESET;
            sync1_q <= '0;
            sync2_q <= '0;
            phase_q <= '0;
            bunch_q <= '0;
            out_q <= '0;
            tnum_q <= '0; // [RQ18]
            rdata_q <= '0;
        end
        else
        begin
            sync1_q <= TRIG_IN;
            sync2_q <= sync1_q;
            phase_q <= phase_q + 1'b1;
            if (tick)
                bunch_q <= bunch_q + 1'b1;
            if (tick)
                out_q <= out_now; // [RQ5]
            if (TRIG_ACCEPT_IN)
                tnum_q <= tnum_next; // [RQ16]
            if (REG_WR_IN && REG_SEL_IN < REG_CONTROL)
                cfg_q[REG_SEL_IN[1:0]] <= REG_WDATA_IN; // [RQ14]
            if (REG_WR_IN && REG_SEL_IN == REG_CONTROL)
                ctl_q <= {24'h000000, REG_WDATA_IN[7:0]};
            if (REG_RD_IN)
                rdata_q <= rd_mux;
        end
    end

    // pending stream words; a new event wins over the clear of the same slot
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            pend_in_v_q <= '0;
            pend_tn_v_q <= '0;
            for (int r = 0; r < NUM_PAIRS; r++)
                pend_in_q[r] <= '0;
            pend_tn_q[0] <= '0;
            pend_tn_q[1] <= '0;
        end
        else
        begin
            for (int r = 0; r < NUM_PAIRS; r++)
            begin
                if (take && src_sel == 3'(r))
                    pend_in_v_q[r] <= 1'b0;
                if (tick && pair_prim[r])
                begin
                    pend_in_v_q[r] <= 1'b1;
                    pend_in_q[r] <= tsv_status(TYPE_INPUT_BASE + 4'(r), {pat_now[2 * r + 1], pat_now[2 * r], prim_bunch[r]}); // [RQ15] [RQ3]
                end
            end
            if (take && src_sel == 3'h4)
                pend_tn_v_q[0] <= 1'b0;
            if (take && src_sel == 3'h5)
                pend_tn_v_q[1] <= 1'b0;
            if (TRIG_ACCEPT_IN)
            begin
                pend_tn_v_q <= 2'b11;
                pend_tn_q[0] <= tn_low_word;
                pend_tn_q[1] <= tn_high_word;
            end
        end
    end

    // hit capture with veto lookup
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            hit_cap_q <= 1'b0;
            hit_q <= '0;
            ram_rd_q <= '0;
        end
        else
        begin
            if (hit_done)
                hit_cap_q <= 1'b0;
            if (hit_take)
            begin
                hit_cap_q <= 1'b1;
                hit_q <= HIT_DATA_IN;
                ram_rd_q <= ram[HIT_BUNCH_IN]; // [RQ7]
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (ram_we)
            ram[ram_waddr] <= out_now; // [RQ6] [RQ8]
    end

    assign REG_RDATA_OUT = rdata_q;
    assign HIT_READY_OUT = !hit_cap_q;
    assign TRIG_OUT = out_q;
    assign BUNCH_OUT = bunch_q;
endmodule

// ---- tb/tsv_trigger_veto_checker.sv ----
// concurrent checks on the ports of the trigger sampling and veto block
`timescale 1ns/1ps
module tsv_trigger_veto_checker
    import tsv_pkg::*;
(
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic REG_RD_IN,
    input wire logic [2:0] REG_SEL_IN,
    input wire logic [31:0] REG_RDATA_OUT,
    input wire logic HIT_VALID_IN,
    input wire logic HIT_READY_OUT,
    input wire logic STREAM_VALID_OUT,
    input wire logic [31:0] STREAM_DATA_OUT,
    input wire logic STREAM_READY_IN,
    input wire logic [NUM_PAIRS-1:0] TRIG_OUT,
    input wire logic [7:0] BUNCH_OUT
);
    default clocking @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    chk_reset_clear: assert property (disable iff (1'b0) RST_IN |-> TRIG_OUT == 4'h0 && !STREAM_VALID_OUT)
        else $error("outputs not clear in reset");
    chk_status_code: assert property (STREAM_VALID_OUT && !STREAM_DATA_OUT[0] |-> STREAM_DATA_OUT[3:0] == STATUS_TAG
        && STREAM_DATA_OUT[7:4] >= TYPE_TRIG_NUM_LOW)
        else $error("status word badly coded");
    chk_stream_hold: assert property (STREAM_VALID_OUT && !STREAM_READY_IN |=> STREAM_VALID_OUT && $stable(STREAM_DATA_OUT))
        else $error("stream word dropped while stalled");
    chk_refused_read: assert property (REG_RD_IN && REG_SEL_IN[2:1] == 2'b11 |=> REG_RDATA_OUT == 32'h0)
        else $error("unmapped index read not zero");
    chk_ctl_unused: assert property (REG_RD_IN && REG_SEL_IN == REG_CONTROL |=> REG_RDATA_OUT[31:26] == 6'h0
        && REG_RDATA_OUT[15:8] == 8'h0)
        else $error("unused control bits not zero");
    chk_flag_pairs: assert property (REG_RD_IN && REG_SEL_IN == REG_CONTROL |=>
        (REG_RDATA_OUT[25:16] & (REG_RDATA_OUT[25:16] >> 1) & 10'h155) == 10'h0)
        else $error("spy queue both empty and full");
    chk_bunch_step: assert property ($changed(BUNCH_OUT) |=> $stable(BUNCH_OUT)[*7]
        ##1 BUNCH_OUT == $past(BUNCH_OUT) + 8'h1)
        else $error("bunch counter step wrong");
    chk_trig_stable: assert property ($changed(TRIG_OUT) |=> $stable(TRIG_OUT)[*7])
        else $error("trigger output changed inside a bunch");
    chk_hit_hold: assert property (HIT_VALID_IN && HIT_READY_OUT |=> !HIT_READY_OUT)
        else $error("hit ready not dropped after capture");
endmodule

// ---- tb/tsv_trig_source.sv ----
// trigger line sources: chip any-hit, external and periodic lines
`timescale 1ns/1ps
module tsv_trig_source (
    input wire logic clk_in,
    input wire logic rst_in,
    output logic [7:0] trig_out
);
    logic [5:0] per_q;
    logic [6:0] fire_q = 7'h0;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            per_q <= 6'h0;
        else
            per_q <= per_q + 6'h1;
    end
    // line 7 pulses periodically, lines 0-6 idle low between pulses
    assign trig_out = {per_q == 6'h3f, fire_q};
    task automatic fire(input logic [6:0] m);
        @(posedge clk_in);
        fire_q <= m;
        @(posedge clk_in);
        fire_q <= 7'h0;
    endtask
endmodule

// ---- tb/tsv_trigger_veto_bench.sv ----
// self-checking bench for the trigger sampling and veto block
`timescale 1ns/1ps
module tsv_trigger_veto_bench
    import tsv_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic acc = 1'b0, veto = 1'b0, wr = 1'b0, rd = 1'b0, hv = 1'b0, sr = 1'b1, rd_q = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [31:0] wd = 32'h0, hd = 32'h0, rdata, sdata, r;
    logic [7:0] trig, bunch, b;
    logic [7:0] hb = 8'h0;
    logic [3:0] tout;
    logic hready, svalid;
    logic [63:0] rq[$], sq[$];
    int mismatches = 0, n_compared = 0;
    tsv_trigger_veto dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .TRIG_IN(trig), .TRIG_ACCEPT_IN(acc),
        .VETO_ENABLE_IN(veto), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_SEL_IN(sel), .REG_WDATA_IN(wd),
        .REG_RDATA_OUT(rdata), .HIT_VALID_IN(hv), .HIT_DATA_IN(hd), .HIT_BUNCH_IN(hb),
        .HIT_READY_OUT(hready), .STREAM_VALID_OUT(svalid), .STREAM_DATA_OUT(sdata),
        .STREAM_READY_IN(sr), .TRIG_OUT(tout), .BUNCH_OUT(bunch));
    tsv_trig_source src_u (.clk_in(clk), .rst_in(rst), .trig_out(trig));
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // oldest note of a queue against a result; an empty queue means an unasked result
    task automatic take(ref logic [63:0] q[$], input logic [31:0] seen);
        logic [63:0] e;
        e = (q.size() > 0) ? q.pop_front() : {32'hffff_ffff, ~seen};
        check(seen & e[63:32], e[31:0]);
    endtask
    always @(posedge clk)
    begin
        rd_q <= rd;
        sr <= $urandom_range(3) != 0;
        if (rd_q)
            take(rq, rdata);
        if (svalid && sr)
            take(sq, sdata);
    end
    task automatic wreg(input logic [2:0] s, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        sel <= s;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] s, input logic [31:0] m, input logic [31:0] v);
        rq.push_back({m, v});
        @(posedge clk);
        rd <= 1'b1;
        sel <= s;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic hit(input logic [7:0] bn, input logic keep);
        logic [31:0] d;
        d = $urandom | 32'h1;
        if (keep)
            sq.push_back({32'hffff_ffff, d});
        @(posedge clk);
        hv <= 1'b1;
        hd <= d;
        hb <= bn;
        @(negedge clk);
        for (int i = 0; i < 50 && !hready; i++)
            @(negedge clk);
        @(posedge clk);
        hv <= 1'b0;
    endtask
    task automatic wait_tout(input logic lvl);
        for (int i = 0; i < 200 && tout[0] !== lvl; i++)
            @(negedge clk);
        check({28'h0, tout}, {31'h0, lvl});
    endtask
    initial
    begin
        void'($urandom(15));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            rreg(3'(i), 32'hffff_ffff, PAIR_CFG_RESET);
        rreg(REG_CONTROL, 32'hffff_ffff, CONTROL_RESET | 32'h02aa_0000);
        r = $urandom;
        wreg(3'h2, r);
        rreg(3'h2, 32'h3fff_ffff, r);
        wreg(3'h2, 32'h0);
        wreg(REG_CONTROL, 32'hffff_ffff);
        rreg(REG_CONTROL, 32'hfc00_ffff, 32'h0000_00ff);
        wreg(REG_CONTROL, 32'h0);
        wreg(3'h6, 32'hffff_ffff);
        rreg(3'h6, 32'hffff_ffff, 32'h0);
        rreg(3'h7, 32'hffff_ffff, 32'h0);
        $display("test registers done");
        // first input enabled with all eight marks, second input disabled
        wreg(3'h0, 32'h1000_00ff);
        sq.push_back({32'hff00_00ff, 32'h0000_00c8});
        src_u.fire(7'h03);
        wait_tout(1'b1);
        repeat (40) @(negedge clk);
        check({28'h0, tout}, 32'h1);
        wait_tout(1'b0);
        rreg(REG_CONTROL, 32'h0003_0000, 32'h0);
        rreg(REG_SPY_DATA, 32'hff00_00ff, 32'h0000_00c8);
        rreg(REG_CONTROL, 32'h0003_0000, 32'h0002_0000);
        $display("test trigger inputs done");
        repeat (2)
        begin
            sq.push_back({32'h0000_00ff, 32'h0000_00a8});
            sq.push_back({32'h0000_00ff, 32'h0000_00b8});
            @(posedge clk);
            acc <= 1'b1;
            @(posedge clk);
            acc <= 1'b0;
            repeat (6) @(posedge clk);
        end
        rreg(REG_CONTROL, 32'h0300_0000, 32'h0100_0000);
        wreg(REG_CONTROL, 32'h0000_0040);
        rreg(REG_SPY_DATA, 32'h0000_00ff, 32'h0000_00a8);
        $display("test trigger numbers done");
        // let every ram entry be rewritten with zero before vetoing
        repeat (2100) @(posedge clk);
        hit(8'h00, 1'b1);
        wreg(REG_CONTROL, 32'h0000_0004);
        veto <= 1'b1;
        sq.push_back({32'hff00_00ff, 32'h0000_00c8});
        src_u.fire(7'h01);
        wait_tout(1'b1);
        b = bunch;
        repeat (120) @(posedge clk);
        wreg(REG_CONTROL, 32'h0000_0084);
        hit(b - 8'h1, 1'b1);
        hit(b + 8'h6, 1'b0);
        sq.push_back({32'hff00_00ff, 32'h0000_00c8});
        src_u.fire(7'h01);
        wait_tout(1'b1);
        b = bunch;
        repeat (120) @(posedge clk);
        hit(b - 8'h1, 1'b0);
        repeat (200) @(posedge clk);
        check(32'(sq.size()), 32'h0);
        $display("test veto done");
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
endmodule
bind tsv_trigger_veto tsv_trigger_veto_checker chk_u (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
    .REG_RD_IN(REG_RD_IN), .REG_SEL_IN(REG_SEL_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .HIT_VALID_IN(HIT_VALID_IN), .HIT_READY_OUT(HIT_READY_OUT), .STREAM_VALID_OUT(STREAM_VALID_OUT),
    .STREAM_DATA_OUT(STREAM_DATA_OUT), .STREAM_READY_IN(STREAM_READY_IN), .TRIG_OUT(TRIG_OUT),
    .BUNCH_OUT(BUNCH_OUT));
